// *** inc/tx_label_regs.vh ***
/*
 * constants for the arinc 429 transmit path and label memory block:
 * control bit positions, fifo geometry, bit timing in 1 MHz data clocks.
 * assumes it is included by bare name from core/ design files.
 */
`ifndef TX_LABEL_REGS_VH
`define TX_LABEL_REGS_VH

// ****************************************************************
// control word bit positions
// ****************************************************************
`define CTL_LABEL_MEM_ACCESS 0
`define CTL_RX1_MATCH 1
`define CTL_RX2_MATCH 2
`define CTL_PARITY_INSERT 3
`define CTL_LOOPBACK_N 4
`define CTL_TX_LOW_SPEED 5
`define CTL_PARITY_SENSE 6
`define CTL_UNSCRAMBLE 7
`define CTL_WIDTH 8

// ****************************************************************
// fifo and label memory geometry
// ****************************************************************
`define TXF_DEPTH 32
`define TXF_AW 5
`define TXF_CW 6
`define TXF_HALF 6'h10
`define LBL_COUNT 16
`define LBL_AW 4
`define LBL_LAST 5'h10

// ****************************************************************
// timing: 1 MHz data clock derived from 50 MHz system clock
// ****************************************************************
`define SYS_CLK_KHZ 50000
`define DATA_CLK_KHZ 1000
`define DATA_DIV (`SYS_CLK_KHZ / `DATA_CLK_KHZ)
`define DIV_W 6
`define HS_HALF_BIT 9'd5
`define LS_HALF_BIT 9'd40
`define HS_GAP 9'd40
`define LS_GAP 9'd320
`define TIM_W 9
`define WORD_BITS 6'd32
`define BITCNT_W 6

`endif

// *** core/label_memory.v ***
/*
 * label store for one receiver: 16 eight-bit entries, sequential load and
 * readback pointer, and a combinational match of a received label.
 * assumes strobes are single-cycle pulses already synchronised.
 */
`include "tx_label_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module label_memory
(
   input wire clk, // system clock
   input wire rst, // sync reset, active high
   input wire restart, // access sequence begins
   input wire load_pulse, // store one label
   input wire read_pulse, // advance readback
   input wire [7:0] load_data, // label to store
   input wire [7:0] match_label, // label of received word
   output wire [7:0] read_data, // label at readback pointer
   output wire matched, // some entry equals match_label
   output wire loading // write sequence not finished
);

reg [7:0] mem [0:`LBL_COUNT-1];
reg [`LBL_AW:0] wr_ptr_q;
reg [`LBL_AW:0] rd_ptr_q;
reg [`LBL_AW:0] wr_ptr_d;
reg [`LBL_AW:0] rd_ptr_d;
reg hit;
integer i;

// ****************************************************************
// pointers; saturate at 16 so extra strobes do nothing
// ****************************************************************
always @*
begin
   wr_ptr_d = wr_ptr_q;
   rd_ptr_d = rd_ptr_q;
   if (restart)
   begin
      wr_ptr_d = {(`LBL_AW+1){1'b0}};
      rd_ptr_d = {(`LBL_AW+1){1'b0}};
   end
   else
   begin
      if (load_pulse && wr_ptr_q != `LBL_LAST)
         wr_ptr_d = wr_ptr_q + 5'h01;
      if (read_pulse && rd_ptr_q != `LBL_LAST)
         rd_ptr_d = rd_ptr_q + 5'h01;
   end
end

// memory contents survive reset, as the labels are configuration
always @(posedge clk)
begin
   if (rst)
   begin
      wr_ptr_q <= `LBL_LAST;
      rd_ptr_q <= `LBL_LAST;
   end
   else
   begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
   end
   if (!restart && load_pulse && wr_ptr_q != `LBL_LAST)
      mem[wr_ptr_q[`LBL_AW-1:0]] <= load_data;
end

// any entry matches, zero included, no empty code exists
always @*
begin
   hit = 1'b0;
   for (i = 0; i < `LBL_COUNT; i = i + 1)
      if (mem[i] == match_label)
         hit = 1'b1;
end

assign matched = hit;
assign read_data = mem[rd_ptr_q[`LBL_AW-1:0]];
assign loading = (wr_ptr_q != `LBL_LAST);

endmodule // label_memory
`default_nettype wire

// *** core/tx_serializer.v ***
/*
 * arinc 429 word serialiser: bit and null halves, word gap, parity insert.
 * assumes a one-cycle data clock tick from the parent.
 */
`include "tx_label_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module tx_serializer
(
   input wire clk, // system clock
   input wire rst, // sync reset, active high
   input wire tick, // one data clock
   input wire start, // take word, only when ready
   input wire [31:0] word, // word, bit 0 sent first
   input wire low_speed, // 80-clock bits when high
   input wire parity_insert, // generate bit 32
   input wire parity_sense, // 0 odd, 1 even
   output reg out_a, // true line output
   output reg out_b, // complementary line output
   output wire ready // idle, may start
);

localparam ST_IDLE = 2'd0;
localparam ST_DATA = 2'd1;
localparam ST_NULL = 2'd2;
localparam ST_GAP = 2'd3;

reg [1:0] state_q;
reg [31:0] shift_q;
reg [`BITCNT_W-1:0] bits_q;
reg [`TIM_W-1:0] tim_q;
reg low_q;

// odd parity makes the total ones count odd
function par_bit;
   input [30:0] d;
   input sense;
   begin
      par_bit = ~(^d) ^ sense;
   end
endfunction

function [`TIM_W-1:0] half_len;
   input ls;
   begin
      half_len = ls ? `LS_HALF_BIT : `HS_HALF_BIT;
   end
endfunction

assign ready = (state_q == ST_IDLE);

// ****************************************************************
// sequencer
// ****************************************************************
always @(posedge clk)
begin
   if (rst)
   begin
      state_q <= ST_IDLE;
      shift_q <= 32'h0;
      bits_q <= {`BITCNT_W{1'b0}};
      tim_q <= {`TIM_W{1'b0}};
      low_q <= 1'b0;
      out_a <= 1'b0;
      out_b <= 1'b0;
   end
   else
   begin
      case (state_q)
         ST_IDLE:
         begin
            out_a <= 1'b0;
            out_b <= 1'b0;
            if (start)
            begin
               shift_q <= parity_insert ? {par_bit(word[30:0], parity_sense), word[30:0]} : word;
               low_q <= low_speed;
               bits_q <= `WORD_BITS;
               tim_q <= half_len(low_speed);
               out_a <= word[0];
               out_b <= ~word[0];
               state_q <= ST_DATA;
            end
         end
         ST_DATA:
            if (tick)
            begin
               if (tim_q == 9'd1)
               begin
                  out_a <= 1'b0;
                  out_b <= 1'b0;
                  tim_q <= half_len(low_q);
                  shift_q <= {1'b0, shift_q[31:1]};
                  bits_q <= bits_q - 6'd1;
                  state_q <= ST_NULL;
               end
               else
                  tim_q <= tim_q - 9'd1;
            end
         ST_NULL:
            if (tick)
            begin
               if (tim_q == 9'd1)
               begin
                  if (bits_q == 6'd0)
                  begin
                     tim_q <= low_q ? `LS_GAP : `HS_GAP;
                     state_q <= ST_GAP;
                  end
                  else
                  begin
                     out_a <= shift_q[0];
                     out_b <= ~shift_q[0];
                     tim_q <= half_len(low_q);
                     state_q <= ST_DATA;
                  end
               end
               else
                  tim_q <= tim_q - 9'd1;
            end
         ST_GAP:
            if (tick)
            begin
               if (tim_q == 9'd1)
                  state_q <= ST_IDLE;
               else
                  tim_q <= tim_q - 9'd1;
            end
         default:
            state_q <= ST_IDLE;
      endcase
   end
end

endmodule // tx_serializer
`default_nettype wire

// *** core/arinc_tx_label_top.v ***
/*
 * arinc 429 transmit fifo and serial path plus per-receiver label memory,
 * label gating of received words, self-test loopback, repeater feed.
 * assumes receiver word decode lives outside and offers a received label
 * with a word-done pulse; host strobes are asynchronous pins.
 */
// Behaviour
// - match enabled: process only labels found stored
// - unmatched word gives no write, no flag
// - label zero matches like any other
// - label bits fixed to serial bits 1-8
// - after access rise, 16 strobes load labels
// - reception held off while labels load
// - after access rise, 16 reads return labels
// - two strobes, lower half first, form word
// - 32-word fifo; full flag, extra loads ignored
// - half flag high below 16 words
// - parity select: parity bit or raw bit 32
// - parity odd when sense low, else even
// - enable starts first bit within 2.5 clocks
// - bit 10/80 clocks, gap 40/320 clocks
// - ready flag when all loaded words sent
// - self test loops output to both receivers
// - line outputs always carry serial data
// - full receive fifo overwritten by new word
// - repeater loads read halves, lower first
// - master reset clears fifo, flags, transmission
// - master reset keeps control contents
`include "tx_label_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module arinc_tx_label_top
(
   input wire SYS_CLK, // 50 MHz clock
   input wire RST, // sync reset, active high
   input wire MASTER_RESET_N, // master reset pin, active low
   input wire CTL_WRITE, // control word write pulse (same domain)
   input wire [`CTL_WIDTH-1:0] CTL_DATA, // control word value
   input wire LOAD_STROBE_ONE_N, // first-half strobe pin
   input wire LOAD_STROBE_TWO_N, // second-half strobe pin
   input wire [15:0] HOST_BUS_IN, // host data bus, low byte labels
   input wire RX1_READ_ENABLE_N, // receiver 1 read strobe pin
   input wire RX2_READ_ENABLE_N, // receiver 2 read strobe pin
   input wire BYTE_SELECT, // 1 upper half, 1 during label access
   input wire TX_ENABLE, // transmit enable pin
   input wire REPEATER_MODE, // reads also feed tx fifo
   input wire [15:0] RX_HALF_DATA, // half word from receiver fifo
   input wire RX1_WORD_DONE, // receiver 1 word decoded pulse
   input wire RX2_WORD_DONE, // receiver 2 word decoded pulse
   input wire [7:0] RX1_LABEL, // receiver 1 serial bits 1-8
   input wire [7:0] RX2_LABEL, // receiver 2 serial bits 1-8
   input wire LINE_IN1, // receiver 1 line data
   input wire LINE_IN2, // receiver 2 line data
   output reg [15:0] HOST_BUS_OUT, // read data to host
   output reg HOST_BUS_OE_N, // low while bus driven
   output reg SERIAL_LINE_OUT, // true line output
   output reg SERIAL_LINE_OUT_N, // complementary line output
   output reg TX_FIFO_FULL_N, // low when 32 words held
   output reg TX_FIFO_HALF_FULL, // high below 16 words
   output reg TX_READY, // all loaded words sent
   output reg RX1_ACCEPT, // store word into rx1 fifo
   output reg RX2_ACCEPT, // store word into rx2 fifo
   output reg RX_FIFO_CLEAR, // clear receive fifos
   output reg RX1_SERIAL, // data into receiver 1
   output reg RX2_SERIAL // data into receiver 2
);

// ****************************************************************
// input synchronisers: two flops, second read only
// ****************************************************************
reg [7:0] sync1_q;
reg [7:0] sync2_q;
reg [7:0] prev_q;
wire tx_a;
wire [7:0] pins = {LINE_IN2, LINE_IN1, MASTER_RESET_N, TX_ENABLE, RX2_READ_ENABLE_N,
                   RX1_READ_ENABLE_N, LOAD_STROBE_TWO_N, LOAD_STROBE_ONE_N};
always @(posedge SYS_CLK)
begin
   if (RST)
   begin
      sync1_q <= 8'h3f;
      sync2_q <= 8'h3f;
      prev_q <= 8'h3f;
   end
   else
   begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
   end
end
wire pl1_fall = prev_q[0] & ~sync2_q[0];
wire pl2_fall = prev_q[1] & ~sync2_q[1];
wire en1_fall = prev_q[2] & ~sync2_q[2];
wire en2_fall = prev_q[3] & ~sync2_q[3];
wire tx_en = sync2_q[4];
wire mr = ~sync2_q[5];
wire line1 = sync2_q[6];
wire line2 = sync2_q[7];

// ****************************************************************
// control word: kept through master reset
// ****************************************************************
reg [`CTL_WIDTH-1:0] ctl_q;
reg restart_q;
always @(posedge SYS_CLK)
begin
   if (RST)
   begin
      ctl_q <= {`CTL_WIDTH{1'b0}};
      restart_q <= 1'b0;
   end
   else
   begin
      restart_q <= 1'b0;
      if (CTL_WRITE)
      begin
         ctl_q <= CTL_DATA;
         restart_q <= ~ctl_q[`CTL_LABEL_MEM_ACCESS] & CTL_DATA[`CTL_LABEL_MEM_ACCESS];
      end
   end
end
wire lbl_access = ctl_q[`CTL_LABEL_MEM_ACCESS];

// ****************************************************************
// label memories
// ****************************************************************
wire [7:0] lbl1_rd;
wire [7:0] lbl2_rd;
wire hit1;
wire hit2;
wire loading1;
wire loading2;
label_memory u_lbl1
(
   .clk (SYS_CLK),
   .rst (RST),
   .restart (restart_q),
   .load_pulse (lbl_access & pl1_fall),
   .read_pulse (lbl_access & en1_fall),
   .load_data (HOST_BUS_IN[7:0]),
   .match_label (RX1_LABEL),
   .read_data (lbl1_rd),
   .matched (hit1),
   .loading (loading1)
);
label_memory u_lbl2
(
   .clk (SYS_CLK),
   .rst (RST),
   .restart (restart_q),
   .load_pulse (lbl_access & pl2_fall),
   .read_pulse (lbl_access & en2_fall),
   .load_data (HOST_BUS_IN[7:0]),
   .match_label (RX2_LABEL),
   .read_data (lbl2_rd),
   .matched (hit2),
   .loading (loading2)
);

// ****************************************************************
// receive gating; overwrite on full is left to the receive fifo
// ****************************************************************
wire lbl_busy = lbl_access & (loading1 | loading2);
wire ok1 = ~ctl_q[`CTL_RX1_MATCH] | hit1;
wire ok2 = ~ctl_q[`CTL_RX2_MATCH] | hit2;
always @(posedge SYS_CLK)
begin
   if (RST)
   begin
      RX1_ACCEPT <= 1'b0;
      RX2_ACCEPT <= 1'b0;
      RX_FIFO_CLEAR <= 1'b0;
      RX1_SERIAL <= 1'b0;
      RX2_SERIAL <= 1'b0;
   end
   else
   begin
      // unmatched words vanish: no accept pulse at all
      RX1_ACCEPT <= RX1_WORD_DONE & ok1 & ~lbl_busy & ~mr;
      RX2_ACCEPT <= RX2_WORD_DONE & ok2 & ~lbl_busy & ~mr;
      RX_FIFO_CLEAR <= mr;
      RX1_SERIAL <= ctl_q[`CTL_LOOPBACK_N] ? line1 : tx_a;
      RX2_SERIAL <= ctl_q[`CTL_LOOPBACK_N] ? line2 : ~tx_a;
   end
end

// ****************************************************************
// transmit fifo: two halves, lower first; repeater feeds reads
// ****************************************************************
reg [31:0] fifo [0:`TXF_DEPTH-1];
reg [`TXF_AW-1:0] wr_q;
reg [`TXF_AW-1:0] rd_q;
reg [`TXF_CW-1:0] cnt_q;
reg [15:0] low_half_q;
reg half_ok_q;
wire rep_low = REPEATER_MODE & ~lbl_access & (en1_fall | en2_fall) & ~BYTE_SELECT;
wire rep_high = REPEATER_MODE & ~lbl_access & (en1_fall | en2_fall) & BYTE_SELECT;
wire take_low = (pl1_fall & ~lbl_access) | rep_low;
wire take_high = ((pl2_fall & ~lbl_access) | rep_high) & half_ok_q;
wire [15:0] high_src = rep_high ? RX_HALF_DATA : HOST_BUS_IN;
wire push = take_high & (cnt_q != `TXF_DEPTH);
wire pop;
wire ser_ready;
wire tx_b;
assign pop = tx_en & ser_ready & (cnt_q != 6'd0) & ~mr;

always @(posedge SYS_CLK)
begin
   if (RST || mr)
   begin
      wr_q <= {`TXF_AW{1'b0}};
      rd_q <= {`TXF_AW{1'b0}};
      cnt_q <= {`TXF_CW{1'b0}};
      low_half_q <= 16'h0;
      half_ok_q <= 1'b0;
   end
   else
   begin
      if (take_low)
      begin
         low_half_q <= rep_low ? RX_HALF_DATA : HOST_BUS_IN;
         half_ok_q <= 1'b1;
      end
      else if (take_high)
         half_ok_q <= 1'b0;
      if (push)
         wr_q <= wr_q + 5'h01;
      if (pop)
         rd_q <= rd_q + 5'h01;
      if (push && !pop)
         cnt_q <= cnt_q + 6'h01;
      else if (pop && !push)
         cnt_q <= cnt_q - 6'h01;
   end
   if (push)
      fifo[wr_q] <= {high_src, low_half_q};
end

// ****************************************************************
// data clock divider and serialiser
// ****************************************************************
reg [`DIV_W-1:0] div_q;
wire tick = (div_q == `DATA_DIV - 1);
always @(posedge SYS_CLK)
begin
   if (RST || tick || pop) // aligned to start, so the first half is full length
      div_q <= {`DIV_W{1'b0}};
   else
      div_q <= div_q + 6'h01;
end

tx_serializer u_ser
(
   .clk (SYS_CLK),
   .rst (RST | mr),
   .tick (tick),
   .start (pop),
   .word (fifo[rd_q]),
   .low_speed (ctl_q[`CTL_TX_LOW_SPEED]),
   .parity_insert (ctl_q[`CTL_PARITY_INSERT]),
   .parity_sense (ctl_q[`CTL_PARITY_SENSE]),
   .out_a (tx_a),
   .out_b (tx_b),
   .ready (ser_ready)
);

// ****************************************************************
// output flops: flags, line, host read bus
// ****************************************************************
always @(posedge SYS_CLK)
begin
   if (RST)
   begin
      SERIAL_LINE_OUT <= 1'b0;
      SERIAL_LINE_OUT_N <= 1'b0;
      TX_FIFO_FULL_N <= 1'b1;
      TX_FIFO_HALF_FULL <= 1'b1;
      TX_READY <= 1'b1;
      HOST_BUS_OUT <= 16'h0;
      HOST_BUS_OE_N <= 1'b1;
   end
   else
   begin
      SERIAL_LINE_OUT <= tx_a;
      SERIAL_LINE_OUT_N <= tx_b;
      TX_FIFO_FULL_N <= ~(cnt_q == `TXF_DEPTH);
      TX_FIFO_HALF_FULL <= (cnt_q < `TXF_HALF);
      TX_READY <= (cnt_q == 6'd0) & ser_ready;
      HOST_BUS_OE_N <= ~(lbl_access & (~sync2_q[2] | ~sync2_q[3]));
      // labels appear in the low byte, upper byte reads zero
      if (lbl_access && en1_fall)
         HOST_BUS_OUT <= {8'h00, lbl1_rd};
      else if (lbl_access && en2_fall)
         HOST_BUS_OUT <= {8'h00, lbl2_rd};
      else if (!lbl_access || (sync2_q[2] && sync2_q[3]))
         HOST_BUS_OUT <= 16'h0;
   end
end

endmodule // arinc_tx_label_top
`default_nettype wire

// *** tb/arinc_tx_label_top_monitor.sv ***
/*
 * checker for the transmit path, label gating and master reset of the top.
 * assumes one clock domain and that control words arrive on CTL_WRITE.
 */
`include "tx_label_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module arinc_tx_label_monitor
(
   input wire logic SYS_CLK, // system clock
   input wire logic RST, // sync reset
   input wire logic MASTER_RESET_N, // master reset pin
   input wire logic CTL_WRITE, // control write pulse
   input wire logic [`CTL_WIDTH-1:0] CTL_DATA, // control word
   input wire logic TX_ENABLE, // transmit enable
   input wire logic RX1_WORD_DONE, // rx1 word decoded
   input wire logic SERIAL_LINE_OUT, // true line
   input wire logic SERIAL_LINE_OUT_N, // complementary line
   input wire logic TX_FIFO_FULL_N, // full flag
   input wire logic TX_FIFO_HALF_FULL, // half flag
   input wire logic TX_READY, // ready flag
   input wire logic RX1_ACCEPT, // rx1 store
   input wire logic RX1_SERIAL, // rx1 data
   input wire logic RX2_SERIAL, // rx2 data
   input wire logic HOST_BUS_OE_N, // bus drive
   input wire logic RX_FIFO_CLEAR // receive clear
);
   // ****************************************************************
   // helper state
   // ****************************************************************
   logic [7:0] ctl_q;
   logic [11:0] hi_q;
   logic [11:0] lo_q;
   logic [3:0] age_q;
   wire logic line_any = SERIAL_LINE_OUT | SERIAL_LINE_OUT_N;

   // mirror control, low and age counters saturate so long idles stay harmless
   always @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         ctl_q <= 8'h00;
         hi_q <= 12'h0;
         lo_q <= 12'h0;
         age_q <= 4'hf;
      end
      else
      begin
         if (CTL_WRITE)
            ctl_q <= CTL_DATA;
         hi_q <= SERIAL_LINE_OUT ? hi_q + 12'h1 : 12'h0;
         lo_q <= line_any ? 12'h0 : (lo_q == 12'hfff ? lo_q : lo_q + 12'h1);
         age_q <= RX1_WORD_DONE ? 4'h0 : (age_q == 4'hf ? age_q : age_q + 4'h1);
      end
   end

   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   sequence s_mr_held;
      !MASTER_RESET_N [*6];
   endsequence
   sequence s_first_bit;
      ##[1:135] line_any;
   endsequence

   property p_pair_excl;
      !(SERIAL_LINE_OUT && SERIAL_LINE_OUT_N);
   endproperty
   property p_bit_len;
      $fell(SERIAL_LINE_OUT) |-> hi_q == (ctl_q[5] ? 12'd2000 : 12'd250);
   endproperty
   property p_null_len;
      $rose(line_any) |-> lo_q >= 12'd250;
   endproperty
   property p_start;
      $rose(TX_ENABLE) && !TX_READY && !line_any |-> s_first_bit;
   endproperty
   property p_accept;
      RX1_ACCEPT |-> age_q < 4'h8;
   endproperty
   property p_bus_drive;
      !HOST_BUS_OE_N |-> ctl_q[0];
   endproperty
   property p_loop;
      !ctl_q[4] && SERIAL_LINE_OUT |-> ##[0:3] (RX1_SERIAL && !RX2_SERIAL);
   endproperty
   property p_full_half;
      !TX_FIFO_FULL_N |-> !TX_FIFO_HALF_FULL;
   endproperty
   property p_mr;
      s_mr_held |-> TX_READY && TX_FIFO_FULL_N && TX_FIFO_HALF_FULL && !line_any && RX_FIFO_CLEAR;
   endproperty

   a_pair_excl: assert property (p_pair_excl) else $error("line pair both high");
   a_bit_len: assert property (p_bit_len) else $error("data half wrong length");
   a_null_len: assert property (p_null_len) else $error("null too short");
   a_start: assert property (p_start) else $error("first bit late");
   a_accept: assert property (p_accept) else $error("accept without word");
   a_bus_drive: assert property (p_bus_drive) else $error("bus driven outside access");
   a_loop: assert property (p_loop) else $error("self test path wrong");
   a_full_half: assert property (p_full_half) else $error("full but half flag high");
   a_mr: assert property (p_mr) else $error("master reset left state");
endmodule // arinc_tx_label_monitor

bind arinc_tx_label_top arinc_tx_label_monitor mon (.*);
`default_nettype wire

// *** tb/line_rx.sv ***
/*
 * far-side line receiver: turns the true and complementary outputs into words.
 * assumes nulls under 400 cycles sit inside a word, longer ones are gaps.
 */
`timescale 1ns/1ns
`default_nettype none

module line_rx
(
   input wire logic clk, // system clock
   input wire logic rst, // sync reset
   input wire logic out_p, // true line output
   input wire logic out_n, // complementary line output
   output logic [31:0] word, // last word decoded
   output logic done // one pulse per word
);
   logic pa_q;
   logic pb_q;
   logic [5:0] cnt_q;
   logic [9:0] quiet_q;
   wire logic rise = (out_p & ~pa_q) | (out_n & ~pb_q);
   wire logic [5:0] idx = (quiet_q > 10'd400) ? 6'd0 : cnt_q;

   // a long quiet resyncs the bit count, so a dropped word cannot shift later ones
   always @(posedge clk)
   begin
      pa_q <= out_p;
      pb_q <= out_n;
      done <= 1'b0;
      quiet_q <= rst ? 10'h3ff : (out_p | out_n) ? 10'd0 : (quiet_q == 10'h3ff ? quiet_q : quiet_q + 10'd1);
      if (rst)
         cnt_q <= 6'd0;
      else if (rise)
      begin
         word[idx[4:0]] <= out_p;
         cnt_q <= (idx == 6'd31) ? 6'd0 : idx + 6'd1;
         done <= (idx == 6'd31);
      end
   end
endmodule // line_rx
`default_nettype wire

// *** tb/tb.sv ***
/*
 * bench for the transmit path and label memory: queue model of the fifo.
 * assumes the design top and the line receiver model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module tb;
   logic SYS_CLK = 1'b0, RST = 1'b1, MASTER_RESET_N = 1'b1, CTL_WRITE = 1'b0;
   logic LOAD_STROBE_ONE_N = 1'b1, LOAD_STROBE_TWO_N = 1'b1, BYTE_SELECT = 1'b0;
   logic RX1_READ_ENABLE_N = 1'b1, RX2_READ_ENABLE_N = 1'b1, TX_ENABLE = 1'b0;
   logic REPEATER_MODE = 1'b0, RX1_WORD_DONE = 1'b0, RX2_WORD_DONE = 1'b0;
   logic LINE_IN1 = 1'b0, LINE_IN2 = 1'b0;
   logic [7:0] CTL_DATA = 8'h10, RX1_LABEL = 8'h00, RX2_LABEL = 8'h00;
   logic [15:0] HOST_BUS_IN = 16'h0, RX_HALF_DATA = 16'h0;
   wire logic [15:0] HOST_BUS_OUT;
   wire logic HOST_BUS_OE_N, SERIAL_LINE_OUT, SERIAL_LINE_OUT_N, TX_FIFO_FULL_N, TX_FIFO_HALF_FULL;
   wire logic TX_READY, RX1_ACCEPT, RX2_ACCEPT, RX_FIFO_CLEAR, RX1_SERIAL, RX2_SERIAL;
   wire logic [31:0] word;
   wire logic done;
   logic [31:0] q[$];
   logic [7:0] lbl [2][16];
   logic [7:0] cv = 8'h10;
   logic [7:0] m;
   int n_fail = 0, checks_done = 0, cycles = 0, i;

   arinc_tx_label_top uut (.*);
   line_rx far (.clk(SYS_CLK), .rst(RST), .out_p(SERIAL_LINE_OUT), .out_n(SERIAL_LINE_OUT_N), .word(word), .done(done));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge SYS_CLK);
   endtask
   task automatic ctl(input logic [7:0] v);
      CTL_DATA = v;
      cv = v;
      CTL_WRITE = 1'b1;
      step(1);
      CTL_WRITE = 1'b0;
      step(1);
   endtask
   // strobe held well past the pin synchroniser before release
   task automatic pl(input int r, input logic [15:0] d);
      HOST_BUS_IN = d;
      if (r == 1)
         LOAD_STROBE_ONE_N = 1'b0;
      else
         LOAD_STROBE_TWO_N = 1'b0;
      step(4);
      LOAD_STROBE_ONE_N = 1'b1;
      LOAD_STROBE_TWO_N = 1'b1;
      step(4);
   endtask
   task automatic push(input logic [31:0] w);
      pl(1, w[15:0]);
      pl(2, w[31:16]);
      if (q.size() < 32)
         q.push_back(w);
   endtask
   task automatic rd(input int r, input logic [7:0] e);
      if (r == 0)
         RX1_READ_ENABLE_N = 1'b0;
      else
         RX2_READ_ENABLE_N = 1'b0;
      step(6);
      chk(HOST_BUS_OUT[7:0], e);
      chk(HOST_BUS_OE_N, 1'b0);
      RX1_READ_ENABLE_N = 1'b1;
      RX2_READ_ENABLE_N = 1'b1;
      step(4);
   endtask
   task automatic wd(input logic [7:0] l, input logic e);
      logic [3:0] a1, a2;
      a1 = 4'h0;
      a2 = 4'h0;
      RX1_LABEL = l;
      RX2_LABEL = 8'($urandom);
      RX1_WORD_DONE = 1'b1;
      RX2_WORD_DONE = 1'b1;
      step(1);
      RX1_WORD_DONE = 1'b0;
      RX2_WORD_DONE = 1'b0;
      repeat (7)
      begin
         a1 = a1 + {3'b0, RX1_ACCEPT};
         a2 = a2 + {3'b0, RX2_ACCEPT};
         step(1);
      end
      chk(a1, e);
      chk(a2, 1);
   endtask
   function automatic logic [31:0] expw(input logic [31:0] w, input logic [7:0] c);
      if (!c[3])
         return w;
      return {c[6] ? ^w[30:0] : ~^w[30:0], w[30:0]};
   endfunction
   task automatic get();
      int k;
      k = 0;
      while (done !== 1'b1 && k < 20000)
      begin
         step(1);
         k++;
      end
      chk(word, expw(q.pop_front(), cv));
      step(1);
   endtask
   task automatic ready();
      int k;
      k = 0;
      while (TX_READY !== 1'b1 && k < 4000)
      begin
         step(1);
         k++;
      end
      chk(TX_READY, 1'b1);
   endtask
   task automatic results();
      if (n_fail == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ****************************************************************
   // clock, timeout, line noise
   // ****************************************************************
   initial forever #10 SYS_CLK = ~SYS_CLK;
   // ceiling sits well above four high speed words plus setup
   always @(posedge SYS_CLK)
   begin
      cycles++;
      if (cycles == 120000)
      begin
         n_fail++;
         results();
      end
   end
   always @(negedge SYS_CLK) {LINE_IN1, LINE_IN2} <= 2'($urandom);

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      i = $urandom(32'h379bfeec);
      step(3);
      RST = 1'b0;
      step(3);
      // load both label stores, then read them back
      ctl(8'h10);
      ctl(8'h11);
      BYTE_SELECT = 1'b1;
      for (i = 0; i < 16; i++)
      begin
         lbl[0][i] = (i == 5) ? 8'h00 : 8'($urandom);
         lbl[1][i] = 8'($urandom);
         pl(1, {8'($urandom), lbl[0][i]});
         pl(2, {8'($urandom), lbl[1][i]});
      end
      ctl(8'h10);
      ctl(8'h11);
      for (i = 0; i < 16; i++)
      begin
         rd(0, lbl[0][i]);
         rd(1, lbl[1][i]);
      end
      BYTE_SELECT = 1'b0;
      // label gating: rx1 matching with unscramble set, rx2 open
      ctl(8'h92);
      do
         m = 8'($urandom);
      while (m inside {lbl[0]});
      wd(8'h00, 1'b1);
      wd(lbl[0][15], 1'b1);
      wd(m, 1'b0);
      // fill past full with self test on, then master reset
      ctl(8'h08);
      for (i = 1; i <= 33; i++)
      begin
         push($urandom);
         chk(TX_FIFO_HALF_FULL, q.size() < 16);
         chk(TX_FIFO_FULL_N, q.size() < 32);
      end
      MASTER_RESET_N = 1'b0;
      step(8);
      MASTER_RESET_N = 1'b1;
      step(4);
      q.delete();
      chk({TX_READY, TX_FIFO_FULL_N, TX_FIFO_HALF_FULL, SERIAL_LINE_OUT}, 4'b1110);
      // back-to-back words under kept control, then even and raw modes
      push($urandom);
      push($urandom);
      TX_ENABLE = 1'b1;
      get();
      get();
      ready();
      ctl(8'h48);
      push($urandom);
      get();
      ready();
      ctl(8'h40);
      push($urandom);
      get();
      ready();
      results();
   end
endmodule // tb
`default_nettype wire
